// [common/ccs_pkg.sv]
// Shared types and constants for the clock switch and sleep control block
package ccs_pkg;
    // ***********************
    // Register map
    // ***********************
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam logic [1:0] OFF_OSC_CTRL = 2'h0;
    localparam logic [1:0] OFF_SEC_CTRL = 2'h1;
    localparam logic [1:0] OFF_PM_STATUS = 2'h2;
    localparam int BIT_SECONDARY_RUN_MODE = 6;
    localparam int BIT_TMR_OSC_EN = 3;
    localparam logic [1:0] SEL_PRI = 2'h0;
    localparam logic [1:0] SEL_SEC = 2'h1;
    localparam logic [2:0] FREQ_SLOW_RC = 3'h0;
    localparam logic [2:0] FREQ_RST = 3'h0;
    localparam logic [1:0] SEL_RST = 2'h0;
    // Primary configurations that use the fast internal oscillator
    localparam logic [3:0] CFG_FAST_INTERNAL_OSCILLATOR_A = 4'h8;
    localparam logic [3:0] CFG_FAST_INTERNAL_OSCILLATOR_B = 4'h9;

    // ***********************
    // Timing
    // ***********************
    localparam int OLD_CYC = 2;
    localparam int NEW_CYC_MIN = 3;
    localparam int NEW_CYC_MAX = 4;
    localparam int CLK_SYS_NS = 100;
    localparam int TCY_NS = 400;
    localparam int GUARD_RAW = (TCY_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
    localparam int GUARD_CYC = (GUARD_RAW < 1) ? 1 : GUARD_RAW;

    // ***********************
    // Types
    // ***********************
    // Order matches the pin index of each source
    typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_FAST_INTERNAL_OSCILLATOR, SRC_SLOW_RC} ccs_src_t;
    typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_SLEEP} ccs_mode_t;
    localparam int PIN_STABLE = 4;
    localparam int PIN_W = 5;
    typedef struct packed {
        logic idle_en;
        logic [2:0] freq_sel;
        logic pri_flag;
        logic internal_osc_stable_flag_flag;
        logic [1:0] clk_sel;
    } ccs_osc_ctrl_t;
    typedef struct packed {
        logic secondary_run_mode;
        logic pri_flag;
        logic internal_osc_stable_flag_flag;
    } ccs_flags_t;
endpackage : ccs_pkg

// [hdl/ccs_clock_switch.sv]
// Clock source switching, source status flags and sleep mode selection
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Switch takes two old-source cycles plus three to four new-source cycles.
// - Primary flag, control bit 3, set while primary clock drives the device.
// - Internal-stable flag, control bit 2, set when fast oscillator gives stable clock.
// - Secondary-running flag, timer control bit 6, set while timer oscillator clocks device.
// - Normally at most one source flag is set at a time.
// - All flags clear means slow RC clocking or fast oscillator not stable.
// - Internal primary configuration may show primary and internal-stable flags together.
// - Moving to an RC mode at same frequency clears the primary flag.
// - Sleep trigger enters full sleep or idle, chosen by idle enable.
// - Idle enable is sampled when the sleep trigger executes.
// - A later sleep uses the idle enable value current at that time.
// - One instruction cycle must pass after wake before another sleep.
// - Select 01 moves to timer oscillator, stops primary, updates both flags.
// - Select 01 with timer oscillator disabled does not enter secondary run.
// - After reset run from primary with its flag set, unless two-speed start.
module ccs_clock_switch (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [ccs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ccs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ccs_pkg::DATA_W-1:0] reg_rdata,
    input wire logic primary_clk_pin,
    input wire logic secondary_clk_pin,
    input wire logic fast_internal_oscillator_clk_pin,
    input wire logic slow_rc_clk_pin,
    input wire logic fast_internal_oscillator_stable_pin,
    input wire logic [3:0] primary_source_config,
    input wire logic two_speed_en,
    input wire logic sleep_exec,
    input wire logic wake_event,
    output ccs_pkg::ccs_src_t clk_source_sel,
    output ccs_pkg::ccs_mode_t power_mode,
    output ccs_pkg::ccs_flags_t status_flags,
    output logic primary_osc_en,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic switch_busy
);
    import ccs_pkg::*;

    // ***********************
    // Declarations
    // ***********************
    logic init_q;
    logic [3:0] cfg_q;
    logic two_speed_q;
    logic idle_en_q;
    logic [2:0] freq_sel_q;
    logic [1:0] clk_sel_q;
    logic tmr_osc_en_q;
    ccs_src_t nxt_src_q;
    logic sw_start_q;
    logic sw_done;
    logic [2:0] guard_q;
    logic [PIN_W-1:0] pin_level;
    logic [PIN_W-1:0] pin_rise;
    logic osc_stable;
    ccs_src_t want_src;
    logic cfg_fast_internal_oscillator;
    logic sleep_ok;
    ccs_osc_ctrl_t osc_wr;

    // Wanted source from the select field; refused secondary keeps current
    function automatic ccs_src_t pick_src(input logic [1:0] sel, input logic [2:0] freq,
                                          input logic tmr_en, input ccs_src_t cur);
        if (sel == SEL_PRI) begin
            return SRC_PRI;
        end else if (sel == SEL_SEC) begin
            return tmr_en ? SRC_SEC : cur;
        end else begin
            return (freq == FREQ_SLOW_RC) ? SRC_SLOW_RC : SRC_FAST_INTERNAL_OSCILLATOR;
        end
    endfunction : pick_src

    // ***********************
    // Oscillator sampling
    // ***********************
    ccs_sync3 #(
        .W(PIN_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pin_in({fast_internal_oscillator_stable_pin, slow_rc_clk_pin, fast_internal_oscillator_clk_pin,
                 secondary_clk_pin, primary_clk_pin}),
        .level(pin_level),
        .rise(pin_rise)
    );

    // Stable indication and source wish
    assign osc_stable = pin_level[PIN_STABLE];
    assign want_src = pick_src(clk_sel_q, freq_sel_q, tmr_osc_en_q, clk_source_sel);
    assign cfg_fast_internal_oscillator = (cfg_q == CFG_FAST_INTERNAL_OSCILLATOR_A) || (cfg_q == CFG_FAST_INTERNAL_OSCILLATOR_B);
    assign osc_wr = ccs_osc_ctrl_t'(reg_wdata);

    // ***********************
    // Transition timing
    // ***********************
    ccs_switch_timer #(
        .OLD_N(OLD_CYC),
        .NEW_N(NEW_CYC_MAX)
    ) u_timer (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .start(sw_start_q),
        .old_tick(pin_rise[clk_source_sel]),
        .new_tick(pin_rise[nxt_src_q]),
        .busy(switch_busy),
        .done(sw_done)
    );

    // Straps caught in the first cycle after reset release
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            init_q <= 1'b0;
            cfg_q <= 4'h0;
            two_speed_q <= 1'b0;
        end else if (!init_q) begin
            init_q <= 1'b1;
            cfg_q <= primary_source_config;
            two_speed_q <= two_speed_en;
        end
    end

    // Start a switch once idle; the done cycle is skipped to avoid a stale compare
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sw_start_q <= 1'b0;
            nxt_src_q <= SRC_PRI;
        end else begin
            sw_start_q <= 1'b0;
            if (init_q && !switch_busy && !sw_start_q && !sw_done
                && power_mode != MODE_SLEEP && want_src != clk_source_sel) begin
                sw_start_q <= 1'b1;
                nxt_src_q <= want_src;
            end
        end
    end

    // After the first cycle out of reset, current source moves only when the timed transition completes
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clk_source_sel <= SRC_PRI;
        end else if (!init_q) begin
            // Two-speed start runs from the fast internal oscillator first
            clk_source_sel <= two_speed_en ? SRC_FAST_INTERNAL_OSCILLATOR : SRC_PRI;
        end else if (sw_done) begin
            clk_source_sel <= nxt_src_q;
        end
    end

    // ***********************
    // Status flags
    // ***********************
    // Derived from the settled source, so they never lead the real clock
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            status_flags <= '0;
        end else if (init_q) begin
            status_flags.pri_flag <= (clk_source_sel == SRC_PRI);
            status_flags.secondary_run_mode <= (clk_source_sel == SRC_SEC);
            // Both set only when the primary is the internal oscillator
            status_flags.internal_osc_stable_flag_flag <= osc_stable && ((clk_source_sel == SRC_FAST_INTERNAL_OSCILLATOR)
                || (clk_source_sel == SRC_PRI && cfg_fast_internal_oscillator));
        end
    end

    // ***********************
    // Register writes
    // ***********************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            idle_en_q <= 1'b0;
            freq_sel_q <= FREQ_RST;
            clk_sel_q <= SEL_RST;
            tmr_osc_en_q <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == OFF_OSC_CTRL) begin
                idle_en_q <= osc_wr.idle_en;
                freq_sel_q <= osc_wr.freq_sel;
                clk_sel_q <= osc_wr.clk_sel;
            end
            if (reg_addr == OFF_SEC_CTRL) begin
                tmr_osc_en_q <= reg_wdata[BIT_TMR_OSC_EN];
            end
        end
    end

    // Read data stands one cycle after the strobe and is zero otherwise
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= '0;
            if (reg_rd) begin
                unique case (reg_addr)
                    OFF_OSC_CTRL: reg_rdata <= {idle_en_q, freq_sel_q, status_flags.pri_flag,
                                                status_flags.internal_osc_stable_flag_flag, clk_sel_q};
                    OFF_SEC_CTRL: begin
                        reg_rdata[BIT_SECONDARY_RUN_MODE] <= status_flags.secondary_run_mode;
                        reg_rdata[BIT_TMR_OSC_EN] <= tmr_osc_en_q;
                    end
                    OFF_PM_STATUS: reg_rdata <= {3'h0, switch_busy, clk_source_sel, power_mode};
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

    // ***********************
    // Sleep and idle control
    // ***********************
    // Sleep is ignored during the post-wake guard and mid-transition
    assign sleep_ok = sleep_exec && init_q && power_mode == MODE_RUN && guard_q == 3'h0
                      && !switch_busy && !sw_start_q;

    // Mode taken from idle enable as it stands when the sleep executes
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            power_mode <= MODE_RUN;
        end else if (sleep_ok) begin
            if (!idle_en_q) begin
                power_mode <= MODE_SLEEP;
            end else if (!(clk_source_sel == SRC_SEC && !tmr_osc_en_q)) begin
                power_mode <= MODE_IDLE;
            end
        end else if (power_mode != MODE_RUN && wake_event) begin
            power_mode <= MODE_RUN;
        end
    end

    // Guard counter loaded on wake, one instruction cycle long
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            guard_q <= 3'h0;
        end else if (power_mode != MODE_RUN && wake_event) begin
            guard_q <= 3'(GUARD_CYC);
        end else if (guard_q != 3'h0) begin
            guard_q <= guard_q - 3'h1;
        end
    end

    // Clock enables; primary kept alive until a switch away has finished
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cpu_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            primary_osc_en <= 1'b1;
        end else begin
            cpu_clk_en <= (power_mode == MODE_RUN);
            periph_clk_en <= (power_mode != MODE_SLEEP);
            primary_osc_en <= (power_mode != MODE_SLEEP) && ((clk_source_sel == SRC_PRI)
                || (switch_busy && nxt_src_q == SRC_PRI) || !init_q);
        end
    end

    // ***********************
    // Checks
    // ***********************
    flags_exclusive_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(status_flags.secondary_run_mode && (status_flags.pri_flag || status_flags.internal_osc_stable_flag_flag))
        && !(status_flags.pri_flag && status_flags.internal_osc_stable_flag_flag && !cfg_fast_internal_oscillator))
        else $error("more than one source flag set");

    sec_flag_src_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        init_q && clk_source_sel == SRC_SEC |=> status_flags.secondary_run_mode)
        else $error("secondary flag missing while on timer oscillator");

    pri_flag_src_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        init_q && $past(init_q) |-> status_flags.pri_flag == ($past(clk_source_sel) == SRC_PRI))
        else $error("primary flag disagrees with source");

    src_on_done_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        init_q && $past(init_q) && clk_source_sel != $past(clk_source_sel) |-> $past(sw_done))
        else $error("source changed without a completed transition");

    switch_len_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        sw_start_q |=> switch_busy [*6])
        else $error("transition shorter than synchroniser and edge count allow");

    sec_refused_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        sw_start_q && nxt_src_q == SRC_SEC |-> $past(tmr_osc_en_q))
        else $error("secondary entered with timer oscillator disabled");

    sleep_pick_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        sleep_ok && !idle_en_q |=> power_mode == MODE_SLEEP ##1 !cpu_clk_en && !periph_clk_en)
        else $error("full sleep not entered");

    idle_pick_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        sleep_ok && idle_en_q && clk_source_sel != SRC_SEC |=> power_mode == MODE_IDLE
        ##1 periph_clk_en && !cpu_clk_en)
        else $error("idle not entered");

    wake_guard_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        power_mode != MODE_RUN && wake_event |=> !sleep_ok [*4])
        else $error("sleep accepted inside post-wake guard");

    primary_stop_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_source_sel == SRC_SEC && !switch_busy && init_q |=> !primary_osc_en)
        else $error("primary oscillator left running on secondary");

    reset_primary_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !init_q ##1 (init_q && !two_speed_q) |=> status_flags.pri_flag)
        else $error("primary flag not set after reset");
endmodule : ccs_clock_switch
`default_nettype wire

// [hdl/ccs_switch_timer.sv]
// Counts old-source then new-source edges for one clock transition
`timescale 1ns/1ps
`default_nettype none
module ccs_switch_timer #(
    parameter int OLD_N = 2,
    parameter int NEW_N = 4
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic start,
    input wire logic old_tick,
    input wire logic new_tick,
    output logic busy,
    output logic done
);
    typedef enum logic [1:0] {ST_IDLE, ST_OLD, ST_NEW} ccs_tmr_st_t;
    ccs_tmr_st_t st_q;
    logic [2:0] cnt_q;

    // Old source edges first, then new source edges
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_IDLE;
            cnt_q <= 3'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (st_q)
                ST_IDLE: begin
                    if (start) begin
                        st_q <= ST_OLD;
                        cnt_q <= 3'h0;
                        busy <= 1'b1;
                    end
                end
                ST_OLD: begin
                    if (old_tick) begin
                        if (cnt_q == 3'(OLD_N - 1)) begin
                            st_q <= ST_NEW;
                            cnt_q <= 3'h0;
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                        end
                    end
                end
                ST_NEW: begin
                    // Edge count from an arbitrary phase spans NEW_N-1 to NEW_N periods
                    if (new_tick) begin
                        if (cnt_q == 3'(NEW_N - 1)) begin
                            st_q <= ST_IDLE;
                            busy <= 1'b0;
                            done <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule : ccs_switch_timer
`default_nettype wire

// [hdl/ccs_sync3.sv]
// Three-stage synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
`default_nettype none
module ccs_sync3 #(
    parameter int W = 5
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // Stage chain; s1 feeds only s2 to keep metastability contained
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Level moves only once two late stages agree; rise lasts one cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            level <= '0;
            rise <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level[i] <= s3_q[i];
                end
                rise[i] <= (s2_q[i] == s3_q[i]) && s3_q[i] && !level[i];
            end
        end
    end
endmodule : ccs_sync3
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the clock switch and sleep control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ccs_pkg::*;
    logic clk_sys;
    logic reset_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic [4:0] osc_cnt_q = 5'h0;
    logic fast_internal_oscillator_stable;
    logic two_speed;
    logic [3:0] pri_cfg;
    logic sleep_exec;
    logic wake_event;
    ccs_src_t clk_source_sel;
    ccs_mode_t power_mode;
    ccs_flags_t status_flags;
    logic primary_osc_en;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic switch_busy;
    logic [7:0] rd_val;
    int failures;
    int checks;
    int span;

    // ***********************
    // Clock and oscillator waveforms
    // ***********************
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Slow divided waveforms so the three-stage sampling sees every edge
    always @(posedge clk_sys) begin
        osc_cnt_q <= osc_cnt_q + 5'h1;
    end

    ccs_clock_switch i_ccs_clock_switch (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .primary_clk_pin(osc_cnt_q[1]),
        .secondary_clk_pin(osc_cnt_q[4]),
        .fast_internal_oscillator_clk_pin(osc_cnt_q[2]),
        .slow_rc_clk_pin(osc_cnt_q[3]),
        .fast_internal_oscillator_stable_pin(fast_internal_oscillator_stable),
        .primary_source_config(pri_cfg),
        .two_speed_en(two_speed),
        .sleep_exec(sleep_exec),
        .wake_event(wake_event),
        .clk_source_sel(clk_source_sel),
        .power_mode(power_mode),
        .status_flags(status_flags),
        .primary_osc_en(primary_osc_en),
        .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en),
        .switch_busy(switch_busy)
    );

    // ***********************
    // Shared tasks
    // ***********************
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask : reg_read

    // One-cycle pulse on sleep or wake, sampled after the taking edge
    task automatic pulse(input bit is_wake);
        @(posedge clk_sys);
        if (is_wake) wake_event <= 1'b1;
        else sleep_exec <= 1'b1;
        @(posedge clk_sys);
        wake_event <= 1'b0;
        sleep_exec <= 1'b0;
        @(negedge clk_sys);
    endtask : pulse

    // Bounded wait for a source, counting busy cycles on the way
    task automatic wait_src(input ccs_src_t s, input int n);
        int i;
        span = 0;
        for (i = 0; i < n && clk_source_sel !== s; i++) begin
            @(negedge clk_sys);
            if (switch_busy === 1'b1) span++;
        end
        if (clk_source_sel !== s) begin
            check("source wait", {6'h0, clk_source_sel}, {6'h0, s});
            end_of_test();
        end
    endtask : wait_src

    task automatic do_reset(input logic [3:0] cfg, input logic ts);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        pri_cfg <= cfg;
        two_speed <= ts;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (8) @(negedge clk_sys);
    endtask : do_reset

    // ***********************
    // Main sequence
    // ***********************
    initial begin
        reset_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fast_internal_oscillator_stable = 1'b0;
        two_speed = 1'b0;
        pri_cfg = 4'h2;
        sleep_exec = 1'b0;
        wake_event = 1'b0;
        failures = 0;
        checks = 0;
        do_reset(4'h2, 1'b0);
        // Reset state and register map
        check("source after reset", {6'h0, clk_source_sel}, {6'h0, SRC_PRI});
        check("flags after reset", {5'h0, status_flags}, 8'h02);
        reg_read(OFF_OSC_CTRL, rd_val);
        check("osc ctrl after reset", rd_val, 8'h08);
        reg_read(OFF_SEC_CTRL, rd_val);
        check("sec ctrl after reset", rd_val, 8'h00);
        reg_write(2'h3, 8'hff);
        reg_write(OFF_PM_STATUS, 8'hff);
        reg_read(2'h3, rd_val);
        check("unmapped read", rd_val, 8'h00);
        reg_read(OFF_PM_STATUS, rd_val);
        check("status read only", rd_val, 8'h00);
        $display("test reset done");
        // Sleep with idle disabled, then refused sleep right after wake
        pulse(1'b0);
        check("mode full sleep", {6'h0, power_mode}, {6'h0, MODE_SLEEP});
        @(negedge clk_sys);
        check("gates in sleep", {6'h0, cpu_clk_en, periph_clk_en}, 8'h00);
        pulse(1'b1);
        check("mode after wake", {6'h0, power_mode}, {6'h0, MODE_RUN});
        pulse(1'b0);
        check("sleep too soon", {6'h0, power_mode}, {6'h0, MODE_RUN});
        repeat (GUARD_CYC) @(posedge clk_sys);
        reg_write(OFF_OSC_CTRL, 8'h80);
        pulse(1'b0);
        check("mode idle", {6'h0, power_mode}, {6'h0, MODE_IDLE});
        @(negedge clk_sys);
        check("gates in idle", {6'h0, cpu_clk_en, periph_clk_en}, 8'h01);
        reg_write(OFF_OSC_CTRL, 8'h00);
        @(negedge clk_sys);
        check("idle kept", {6'h0, power_mode}, {6'h0, MODE_IDLE});
        pulse(1'b1);
        repeat (GUARD_CYC + 1) @(posedge clk_sys);
        $display("test sleep done");
        // Secondary select with timer oscillator off is refused
        reg_write(OFF_OSC_CTRL, 8'h01);
        repeat (200) @(negedge clk_sys);
        check("refused select", {6'h0, clk_source_sel}, {6'h0, SRC_PRI});
        check("refused flags", {5'h0, status_flags}, 8'h02);
        $display("test refused done");
        // Switch to the secondary oscillator
        reg_write(OFF_SEC_CTRL, 8'h08);
        reg_write(OFF_OSC_CTRL, 8'h00);
        reg_write(OFF_OSC_CTRL, 8'h01);
        wait_src(SRC_SEC, 600);
        check("flags at source change", {5'h0, status_flags}, 8'h02);
        check("busy span bounds", 8'((span >= 3 * 32) && (span <= 4 * 32 + 24)), 8'h01);
        @(negedge clk_sys);
        @(negedge clk_sys);
        check("flags secondary run", {5'h0, status_flags}, 8'h04);
        check("primary osc off", {7'h0, primary_osc_en}, 8'h00);
        reg_read(OFF_SEC_CTRL, rd_val);
        check("sec ctrl running", rd_val, 8'h48);
        reg_read(OFF_OSC_CTRL, rd_val);
        check("osc ctrl secondary", rd_val, 8'h01);
        $display("test secondary done");
        // Fast internal source, first unstable then stable
        reg_write(OFF_OSC_CTRL, 8'h12);
        wait_src(SRC_FAST_INTERNAL_OSCILLATOR, 600);
        repeat (3) @(negedge clk_sys);
        check("flags unstable", {5'h0, status_flags}, 8'h00);
        @(posedge clk_sys);
        fast_internal_oscillator_stable <= 1'b1;
        repeat (8) @(negedge clk_sys);
        check("flags stable", {5'h0, status_flags}, 8'h01);
        reg_read(OFF_OSC_CTRL, rd_val);
        check("osc ctrl stable", rd_val, 8'h16);
        $display("test internal done");
        // Internal oscillator as primary shows both flags
        do_reset(CFG_FAST_INTERNAL_OSCILLATOR_A, 1'b0);
        check("internal primary flags", {5'h0, status_flags}, 8'h03);
        $display("test internal primary done");
        // Two-speed start runs from the fast internal source, then returns to primary
        do_reset(4'h2, 1'b1);
        check("two-speed source", {6'h0, clk_source_sel}, {6'h0, SRC_FAST_INTERNAL_OSCILLATOR});
        check("two-speed flags", {5'h0, status_flags}, 8'h01);
        wait_src(SRC_PRI, 200);
        repeat (2) @(negedge clk_sys);
        check("primary after two-speed", {5'h0, status_flags}, 8'h02);
        $display("test two-speed done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
